//--- include/snf_params.svh
// snf_params.svh: constants of the serial memory command front end
// assumes: included by bare name from package and design files
`ifndef SNF_PARAMS_SVH
`define SNF_PARAMS_SVH

// opcode encodings
`define SNF_OP_LATCH_SET    8'h06
`define SNF_OP_LATCH_CLEAR  8'h04
`define SNF_OP_STATUS_READ  8'h05
`define SNF_OP_STATUS_WRITE 8'h01
`define SNF_OP_MEM_READ     8'h03
`define SNF_OP_QUICK_READ   8'h0b
`define SNF_OP_MEM_WRITE    8'h02
`define SNF_OP_SLEEP        8'hb9
`define SNF_OP_IDENT_READ   8'h9f

// status register layout
`define SNF_SR_LATCH_BIT    1
`define SNF_SR_BP_LO        2
`define SNF_SR_BP_HI        3
`define SNF_SR_FIXED_ONE    6
`define SNF_SR_PROT_EN_BIT  7
`define SNF_SR_RESET        8'h40

// address framing
`define SNF_ADDR_W          18
`define SNF_ADDR_BYTES      2'h3
`define SNF_QUICK_BYTES     2'h0

// pin vector positions
`define SNF_PIN_CS          0
`define SNF_PIN_SCK         1
`define SNF_PIN_SI          2
`define SNF_PIN_WP          3
`define SNF_PIN_N           4
`define SNF_PIN_RESET       4'h9

`endif

//--- include/snf_pkg.sv
// snf_pkg: types of the serial memory command front end
// assumes: snf_params.svh on the include path
`include "snf_params.svh"

package snf_pkg;

  // command sequencing states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_OPC  = 5'h02,
    ST_ADDR = 5'h04,
    ST_DATA = 5'h08,
    ST_DONE = 5'h10
  } snf_state_e;

  typedef logic [`SNF_ADDR_W-1:0] snf_addr_t;

endpackage : snf_pkg

//--- include/snf_pin_if.sv
// snf_pin_if: filtered pin levels and edge pulses between filter and core
// assumes: one clock domain, driven by snf_pin_filter only
`timescale 1ns/1ps
`default_nettype none
`include "snf_params.svh"

interface snf_pin_if;
  logic [`SNF_PIN_N-1:0] lvl;   // filtered level
  logic [`SNF_PIN_N-1:0] rise;  // one-cycle rising pulse
  logic [`SNF_PIN_N-1:0] fall;  // one-cycle falling pulse

  modport filt (output lvl, output rise, output fall);
  modport core (input lvl, input rise, input fall);
endinterface : snf_pin_if

`default_nettype wire

//--- core/snf_pin_filter.sv
// snf_pin_filter: three-stage synchroniser and edge finder for the pins
// assumes: pins are asynchronous to i_mclk; link clock far below 200 MHz
`timescale 1ns/1ps
`default_nettype none
`include "snf_params.svh"

module snf_pin_filter
  import snf_pkg::*;
(
  // clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  // raw pins
  input  wire logic [`SNF_PIN_N-1:0] i_pins,
  // filtered side
  snf_pin_if.filt                    pf
);

  logic [`SNF_PIN_N-1:0] s1_q;
  logic [`SNF_PIN_N-1:0] s2_q;
  logic [`SNF_PIN_N-1:0] s3_q;
  logic [`SNF_PIN_N-1:0] lvl_q;
  logic [`SNF_PIN_N-1:0] rise_q;
  logic [`SNF_PIN_N-1:0] fall_q;

  ////////////////////////////////////////////////////////////////////////////
  // per pin: stage one feeds only stage two; level moves once 2 and 3 agree
  genvar g;
  generate
    for (g = 0; g < `SNF_PIN_N; g = g + 1) begin : g_pin
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          s1_q[g]   <= 1'(`SNF_PIN_RESET >> g);
          s2_q[g]   <= 1'(`SNF_PIN_RESET >> g);
          s3_q[g]   <= 1'(`SNF_PIN_RESET >> g);
          lvl_q[g]  <= 1'(`SNF_PIN_RESET >> g);
          rise_q[g] <= 1'b0;
          fall_q[g] <= 1'b0;
        end else begin
          s1_q[g]   <= i_pins[g];
          s2_q[g]   <= s1_q[g];
          s3_q[g]   <= s2_q[g];
          // agreement filter rejects a one-sample glitch
          if (s2_q[g] == s3_q[g]) begin
            lvl_q[g] <= s3_q[g];
          end
          rise_q[g] <= (s2_q[g] == s3_q[g]) && s3_q[g] && !lvl_q[g];
          fall_q[g] <= (s2_q[g] == s3_q[g]) && !s3_q[g] && lvl_q[g];
        end
      end
    end
  endgenerate

  assign pf.lvl  = lvl_q;
  assign pf.rise = rise_q;
  assign pf.fall = fall_q;

endmodule : snf_pin_filter

`default_nettype wire

//--- core/snf_frontend.sv
// snf_frontend: serial slave command front end of a byte-wide memory
// assumes: one master; memory array outside answers i_rd_data combinationally
`timescale 1ns/1ps
`default_nettype none
`include "snf_params.svh"

// What this block does
// - sample input on rise, output on fall
// - clock level at select picks mode 0/3
// - mode 3 counts rises after first toggle
// - first eight bits form the opcode
// - one opcode per selection, fresh select
// - deselected: ignore input, output tristated
// - address and data shift msb first
// - three address bytes, keep low 18 bits
// - unknown opcode ignored until next select
// - latch-set opcode sets write latch
// - latch-clear opcode clears write latch
// - nine opcodes, status read/write encodings
// - normal, quick read and write encodings
// - sleep and ident read encodings
// - write latch clear after power-up
// - writes refused while latch clear
// - status write data never sets latch flag
// - latch cleared at select rise after writes
// - eight-bit status register configures device
// - output driven only for read data
// - latch flag is status bit one
module snf_frontend
  import snf_pkg::*;
(
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  // serial pins
  input  wire logic                   i_cs_n,
  input  wire logic                   i_sck,
  input  wire logic                   i_si,
  input  wire logic                   i_wp_n,
  output logic                        o_so,
  output logic                        o_so_oe_n,
  // command report
  output logic                        o_cmd_valid,
  output logic [7:0]                  o_opcode,
  output logic                        o_mode3,
  output logic [7:0]                  o_status,
  // memory array side
  output logic                        o_rd_req,
  output logic [`SNF_ADDR_W-1:0]      o_rd_addr,
  input  wire logic [7:0]             i_rd_data,
  output logic                        o_wr_valid,
  output logic [`SNF_ADDR_W-1:0]      o_wr_addr,
  output logic [7:0]                  o_wr_data
);

  ////////////////////////////////////////////////////////////////////////////
  // pin filtering
  snf_pin_if pins ();

  snf_pin_filter u_filt (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_pins ({i_wp_n, i_si, i_sck, i_cs_n}),
    .pf     (pins.filt)
  );

  logic cs_fall, cs_rise, sck_rise, sck_fall, sck_lvl, si_lvl, wp_n_lvl, sel;
  assign cs_fall  = pins.fall[`SNF_PIN_CS];
  assign cs_rise  = pins.rise[`SNF_PIN_CS];
  assign sck_rise = pins.rise[`SNF_PIN_SCK];
  assign sck_fall = pins.fall[`SNF_PIN_SCK];
  assign sck_lvl  = pins.lvl[`SNF_PIN_SCK];
  assign si_lvl   = pins.lvl[`SNF_PIN_SI];
  assign wp_n_lvl = pins.lvl[`SNF_PIN_WP];
  assign sel      = !pins.lvl[`SNF_PIN_CS];

  ////////////////////////////////////////////////////////////////////////////
  // state
  snf_state_e           state_q;
  logic                 mode3_q;
  logic                 armed_q;
  logic [2:0]           bit_q;
  logic [6:0]           sh_q;
  logic [1:0]           abyte_q;
  logic [7:0]           cmd_q;
  logic                 cmd_ok_q;
  snf_addr_t            addr_q;
  logic                 wel_q;
  logic                 wpen_q;
  logic [1:0]           bp_q;
  logic                 rd_q;
  logic                 drv_q;
  logic [6:0]           tx_q;
  logic [2:0]           obit_q;
  logic                 so_q;

  logic       take_bit, byte_done, quick;
  logic [7:0] byte_w;
  // mode 3 waits for its first toggle
  assign take_bit  = sck_rise && sel && armed_q && !cs_fall &&
                     (state_q == ST_OPC || state_q == ST_ADDR || state_q == ST_DATA);
  assign byte_w    = {sh_q, si_lvl};
  assign byte_done = take_bit && (bit_q == 3'h7);
  assign quick     = (cmd_q == `SNF_OP_QUICK_READ);

  ////////////////////////////////////////////////////////////////////////////
  // mode detection at select
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      mode3_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (cs_fall) begin
      mode3_q <= sck_lvl;
      armed_q <= !sck_lvl;
    end else if (sck_fall && sel) begin
      armed_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit shifter
  always_ff @(posedge i_mclk) begin
    if (i_rst || !sel || cs_fall) begin
      bit_q <= 3'h0;
      sh_q  <= 7'h00;
    end else if (take_bit) begin
      bit_q <= bit_q + 3'h1;
      sh_q  <= byte_w[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q  <= ST_IDLE;
      cmd_q    <= 8'h00;
      cmd_ok_q <= 1'b0;
      abyte_q  <= 2'h0;
      rd_q     <= 1'b0;
    end else if (cs_rise || !sel) begin
      state_q  <= ST_IDLE;
      rd_q     <= 1'b0;
    end else if (cs_fall) begin
      // each opcode needs a fresh select
      state_q  <= ST_OPC;
      cmd_q    <= 8'h00;
      cmd_ok_q <= 1'b0;
      abyte_q  <= 2'h0;
      rd_q     <= 1'b0;
    end else if (byte_done) begin
      case (state_q)
        ST_OPC: begin
          cmd_q    <= byte_w;
          cmd_ok_q <= 1'b1;
          case (byte_w)
            `SNF_OP_STATUS_READ: begin
              state_q <= ST_DATA;
              rd_q    <= 1'b1;
            end
            `SNF_OP_STATUS_WRITE: state_q <= ST_DATA;
            `SNF_OP_MEM_READ, `SNF_OP_QUICK_READ, `SNF_OP_MEM_WRITE: begin
              state_q <= ST_ADDR;
            end
            `SNF_OP_SLEEP, `SNF_OP_IDENT_READ: state_q <= ST_DONE;
            `SNF_OP_LATCH_SET, `SNF_OP_LATCH_CLEAR: state_q <= ST_DONE;
            default: begin
              cmd_ok_q <= 1'b0;
              state_q  <= ST_DONE;
            end
          endcase
        end
        ST_ADDR: begin
          abyte_q <= abyte_q + 2'h1;
          // quick read adds one dummy byte
          if ((!quick && abyte_q == `SNF_ADDR_BYTES - 2'h1) ||
              (quick && abyte_q == `SNF_QUICK_BYTES - 2'h1)) begin
            state_q <= ST_DATA;
            rd_q    <= (cmd_q != `SNF_OP_MEM_WRITE);
          end
        end
        ST_DATA: state_q <= ST_DATA;
        ST_DONE: state_q <= ST_DONE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      addr_q <= '0;
    end else if (byte_done && state_q == ST_ADDR && abyte_q < `SNF_ADDR_BYTES) begin
      // upper six bits fall off the top
      addr_q <= {addr_q[`SNF_ADDR_W-9:0], byte_w};
    end else if (byte_done && state_q == ST_DATA &&
                 (cmd_q == `SNF_OP_MEM_WRITE || cmd_q == `SNF_OP_MEM_READ || quick)) begin
      // sequential bytes, wraps at the top of the array
      addr_q <= addr_q + snf_addr_t'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write latch and status bits
  logic latch_set_cmd_hit, sr_open;
  assign latch_set_cmd_hit = byte_done && state_q == ST_OPC && byte_w == `SNF_OP_LATCH_SET;
  assign sr_open  = wel_q && !(wpen_q && !wp_n_lvl);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wel_q <= 1'b0;
    end else if (latch_set_cmd_hit) begin
      wel_q <= 1'b1;
    end else if (cs_rise && cmd_ok_q &&
                 (cmd_q == `SNF_OP_LATCH_CLEAR || cmd_q == `SNF_OP_STATUS_WRITE ||
                  cmd_q == `SNF_OP_MEM_WRITE)) begin
      wel_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wpen_q <= 1'(`SNF_SR_RESET >> `SNF_SR_PROT_EN_BIT);
      bp_q   <= 2'h0;
    end else if (byte_done && state_q == ST_DATA && cmd_q == `SNF_OP_STATUS_WRITE &&
                 sr_open) begin
      wpen_q <= byte_w[`SNF_SR_PROT_EN_BIT];
      bp_q   <= byte_w[`SNF_SR_BP_HI:`SNF_SR_BP_LO];
    end
  end

  always_comb begin
    o_status                      = `SNF_SR_RESET;
    o_status[`SNF_SR_PROT_EN_BIT] = wpen_q;
    o_status[`SNF_SR_BP_HI:`SNF_SR_BP_LO] = bp_q;
    o_status[`SNF_SR_LATCH_BIT]   = wel_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory array strobes
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rd_req    <= 1'b0;
      o_rd_addr   <= '0;
      o_wr_valid  <= 1'b0;
      o_wr_addr   <= '0;
      o_wr_data   <= 8'h00;
      o_cmd_valid <= 1'b0;
      o_opcode    <= 8'h00;
    end else begin
      o_cmd_valid <= byte_done && state_q == ST_OPC && byte_w != `SNF_OP_MEM_READ - 8'h03 &&
                     (byte_w == `SNF_OP_LATCH_SET || byte_w == `SNF_OP_LATCH_CLEAR ||
                      byte_w == `SNF_OP_STATUS_READ || byte_w == `SNF_OP_STATUS_WRITE ||
                      byte_w == `SNF_OP_MEM_READ || byte_w == `SNF_OP_QUICK_READ ||
                      byte_w == `SNF_OP_MEM_WRITE || byte_w == `SNF_OP_SLEEP ||
                      byte_w == `SNF_OP_IDENT_READ);
      if (byte_done && state_q == ST_OPC) begin
        o_opcode <= byte_w;
      end
      // fetch one byte ahead of the falling edge that shifts it out
      o_rd_req <= byte_done && cmd_q != `SNF_OP_MEM_WRITE &&
                  ((state_q == ST_ADDR && ((!quick && abyte_q == 2'h2) ||
                                           (quick && abyte_q == 2'h3))) ||
                   (state_q == ST_DATA && cmd_q != `SNF_OP_STATUS_READ &&
                    cmd_q != `SNF_OP_STATUS_WRITE));
      if (byte_done && state_q == ST_ADDR && abyte_q == 2'h2) begin
        o_rd_addr <= {addr_q[`SNF_ADDR_W-9:0], byte_w};
      end else if (byte_done && state_q == ST_DATA) begin
        o_rd_addr <= addr_q + snf_addr_t'(1);
      end
      o_wr_valid <= byte_done && state_q == ST_DATA && cmd_q == `SNF_OP_MEM_WRITE && wel_q;
      if (byte_done && state_q == ST_DATA) begin
        o_wr_addr <= addr_q;
        o_wr_data <= byte_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output
  always_ff @(posedge i_mclk) begin
    if (i_rst || !sel || cs_fall) begin
      obit_q <= 3'h0;
      tx_q   <= 7'h00;
      drv_q  <= 1'b0;
      so_q   <= 1'b0;
    end else if (sck_fall && rd_q && state_q == ST_DATA) begin
      // output moves on falling edge only
      obit_q <= obit_q + 3'h1;
      drv_q  <= 1'b1;
      if (obit_q == 3'h0) begin
        so_q <= (cmd_q == `SNF_OP_STATUS_READ) ? o_status[7] : i_rd_data[7];
        tx_q <= (cmd_q == `SNF_OP_STATUS_READ) ? o_status[6:0] : i_rd_data[6:0];
      end else begin
        so_q <= tx_q[6];
        tx_q <= {tx_q[5:0], 1'b0};
      end
    end
  end

  assign o_so      = so_q;
  assign o_so_oe_n = !(sel && drv_q && rd_q);
  assign o_mode3   = mode3_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [1:0] ncmd_q;
  always_ff @(posedge i_mclk) begin
    if (i_rst || cs_fall) begin
      ncmd_q <= 2'h0;
    end else if (o_cmd_valid && ncmd_q != 2'h3) begin
      ncmd_q <= ncmd_q + 2'h1;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_so_deselect: assert property (!sel |-> o_so_oe_n)
    else $error("output driven while deselected");
  a_so_fall_only: assert property ($changed(so_q) && sel |-> $past(sck_fall))
    else $error("output changed without a falling clock");
  a_mode_capture: assert property (cs_fall |=> mode3_q == $past(sck_lvl))
    else $error("mode not taken from clock level");
  a_mode3_wait: assert property (cs_fall && sck_lvl |=> !armed_q)
    else $error("mode 3 armed before first toggle");
  a_latch_set: assert property ($rose(wel_q) |-> $past(latch_set_cmd_hit))
    else $error("latch set without latch-set opcode");
  a_latch_clear: assert property ($fell(wel_q) |-> $past(cs_rise))
    else $error("latch cleared away from select rise");
  a_write_gate: assert property (o_wr_valid |-> $past(wel_q))
    else $error("memory write while latch clear");
  a_one_opcode: assert property (ncmd_q <= 2'h1)
    else $error("more than one opcode in a selection");
  a_unknown_quiet: assert property (state_q == ST_DONE && !cmd_ok_q |->
                                    o_so_oe_n && !o_wr_valid && !o_rd_req)
    else $error("unknown opcode caused activity");
  a_oe_read_only: assert property (!o_so_oe_n |-> rd_q && state_q == ST_DATA)
    else $error("output driven outside read data");
  a_latch_bit: assert property (o_status[`SNF_SR_LATCH_BIT] == wel_q)
    else $error("status bit one differs from latch");

  c_mode3_select: cover property (cs_fall && sck_lvl);
  c_status_read: cover property (!o_so_oe_n && cmd_q == `SNF_OP_STATUS_READ);
  c_mem_write: cover property (o_wr_valid);
  c_unknown_op: cover property (state_q == ST_DONE && !cmd_ok_q);

endmodule : snf_frontend

`default_nettype wire

//--- tb/snf_spi_master.sv
// snf_spi_master: behavioural single spi master driving the front end pins
// assumes: pins change on falling i_mclk, sck half period of 8 mclk (80 ns period)
`timescale 1ns/1ps
`default_nettype none

module snf_spi_master (
  // clock
  input  wire logic i_mclk,
  // link pins
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si,
  input  wire logic i_so,
  input  wire logic i_so_oe_n
);
  logic mode3_q;
  logic last_so_q;
  logic so_line;

  initial begin
    o_cs_n  = 1'b1;
    o_sck   = 1'b0;
    o_si    = 1'b0;
    mode3_q = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // released so shows the inverse of its last bit, so a stale level never passes
  always @(posedge i_mclk) begin
    if (i_so_oe_n === 1'b0) last_so_q <= i_so;
  end
  assign so_line = (i_so_oe_n === 1'b0) ? i_so : ~last_so_q;

  task automatic half();
    repeat (8) @(negedge i_mclk);
  endtask : half

  ////////////////////////////////////////////////////////////////////////////
  // fresh select, clock idles per mode
  task automatic sel(input logic m3);
    mode3_q = m3;
    o_sck   = m3;
    half();
    o_cs_n  = 1'b0;
    half();
  endtask : sel

  // msb first, si set at the fall, so taken at the rise
  task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nb; i--) begin
      o_sck = 1'b0;
      o_si  = tx[i];
      half();
      o_sck = 1'b1;
      rx[i] = so_line;
      half();
    end
  endtask : shift

  // mode 0 returns the clock low; si wiggles while deselected
  task automatic desel();
    if (!mode3_q) begin
      o_sck = 1'b0;
      half();
    end
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    half();
    half();
  endtask : desel
endmodule : snf_spi_master

`default_nettype wire

//--- tb/spi_nvram_command_frontend_test.sv
// spi_nvram_command_frontend_test: scenario bench of the command front end
// assumes: snf_spi_master on the pins; array modelled as address xor 8'h5a
`timescale 1ns/1ps
`default_nettype none
`include "snf_params.svh"

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR t=%0t got %0h expected %0h", $time, (got), (exp)); end end

module spi_nvram_command_frontend_test;
  import snf_pkg::*;
  logic                   i_mclk;
  logic                   i_rst;
  logic                   i_wp_n;
  logic                   cs_n, sck, si, so, so_oe_n;
  logic                   o_cmd_valid, o_mode3, o_rd_req, o_wr_valid;
  logic [7:0]             o_opcode, o_status, o_wr_data, i_rd_data;
  logic [`SNF_ADDR_W-1:0] o_rd_addr, o_wr_addr, wr_addr_q;
  logic [7:0]             wr_data_q, rx;
  logic [7:0]             cs_hist_q;
  int                     error_cnt, num_checks, cmd_cnt, wr_cnt, oe_cnt, oe_bad, rd_cnt;
  int                     c0, w0, o0, r0;

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // design and master
  snf_frontend u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck),
    .i_si(si), .i_wp_n(i_wp_n), .o_so(so), .o_so_oe_n(so_oe_n),
    .o_cmd_valid(o_cmd_valid), .o_opcode(o_opcode), .o_mode3(o_mode3),
    .o_status(o_status), .o_rd_req(o_rd_req), .o_rd_addr(o_rd_addr),
    .i_rd_data(i_rd_data), .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data));
  snf_spi_master u_mst (.i_mclk(i_mclk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si),
    .i_so(so), .i_so_oe_n(so_oe_n));

  // array answers combinationally, a known pattern per address
  assign i_rd_data = o_rd_addr[7:0] ^ 8'h5a;

  // event counters; oe checked only once select has been high 8 cycles
  always @(posedge i_mclk) begin
    cs_hist_q <= {cs_hist_q[6:0], cs_n};
    if (o_cmd_valid === 1'b1) cmd_cnt <= cmd_cnt + 1;
    if (so_oe_n === 1'b0) oe_cnt <= oe_cnt + 1;
    if (o_rd_req === 1'b1) rd_cnt <= rd_cnt + 1;
    if (cs_hist_q === 8'hff && so_oe_n !== 1'b1) oe_bad <= oe_bad + 1;
    if (o_wr_valid === 1'b1) begin
      wr_cnt    <= wr_cnt + 1;
      wr_addr_q <= o_wr_addr;
      wr_data_q <= o_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic xb(input logic [7:0] tx, output logic [7:0] r);
    u_mst.shift(tx, 8, r);
  endtask : xb

  task automatic cmd1(input logic [7:0] op, input logic m3);
    u_mst.sel(m3);
    xb(op, rx);
    u_mst.desel();
  endtask : cmd1

  task automatic stat_wr(input logic [7:0] v);
    // latch set in an earlier selection
    cmd1(`SNF_OP_LATCH_SET, 1'b0);
    u_mst.sel(1'b0);
    xb(`SNF_OP_STATUS_WRITE, rx);
    xb(v, rx);
    u_mst.desel();
  endtask : stat_wr

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  // reset state, status read with a stray second opcode byte
  task automatic s_power();
    `CHK(o_status, 8'h40)
    `CHK(so_oe_n, 1'b1)
    c0 = cmd_cnt;
    u_mst.sel(1'b0);
    xb(`SNF_OP_STATUS_READ, rx);
    xb(`SNF_OP_LATCH_SET, rx);
    u_mst.desel();
    `CHK(rx, 8'h40)
    `CHK(o_mode3, 1'b0)
    `CHK(cmd_cnt, c0 + 1)
    `CHK(o_status[`SNF_SR_LATCH_BIT], 1'b0)
  endtask : s_power

  // latch set in mode 3, read back, clear
  task automatic s_latch();
    cmd1(`SNF_OP_LATCH_SET, 1'b1);
    `CHK(o_mode3, 1'b1)
    `CHK(o_status, 8'h42)
    u_mst.sel(1'b1);
    xb(`SNF_OP_STATUS_READ, rx);
    xb(8'h00, rx);
    u_mst.desel();
    `CHK(rx, 8'h42)
    cmd1(`SNF_OP_LATCH_CLEAR, 1'b0);
    `CHK(o_status, 8'h40)
  endtask : s_latch

  // refused write, then a burst over the wrap point
  task automatic s_write();
    w0 = wr_cnt;
    u_mst.sel(1'b0);
    xb(`SNF_OP_MEM_WRITE, rx);
    xb(8'h00, rx);
    xb(8'h00, rx);
    xb(8'h10, rx);
    xb(8'haa, rx);
    u_mst.desel();
    `CHK(wr_cnt, w0)
    cmd1(`SNF_OP_LATCH_SET, 1'b0);
    u_mst.sel(1'b0);
    xb(`SNF_OP_MEM_WRITE, rx);
    xb(8'h03, rx);
    xb(8'hff, rx);
    xb(8'hff, rx);
    xb(8'ha5, rx);
    `CHK(wr_addr_q, 18'h3ffff)
    `CHK(wr_data_q, 8'ha5)
    xb(8'h3c, rx);
    u_mst.desel();
    `CHK(wr_cnt, w0 + 2)
    `CHK(wr_addr_q, 18'h00000)
    `CHK(wr_data_q, 8'h3c)
    `CHK(o_status, 8'h40)
  endtask : s_write

  // upper address bits dropped, normal and quick read
  task automatic s_read();
    r0 = rd_cnt;
    u_mst.sel(1'b0);
    xb(`SNF_OP_MEM_READ, rx);
    xb(8'hc1, rx);
    xb(8'h23, rx);
    xb(8'h45, rx);
    xb(8'h00, rx);
    `CHK(rx, 8'h45 ^ 8'h5a)
    xb(8'h00, rx);
    `CHK(rx, 8'h46 ^ 8'h5a)
    u_mst.desel();
    u_mst.sel(1'b1);
    xb(`SNF_OP_QUICK_READ, rx);
    xb(8'h00, rx);
    xb(8'h00, rx);
    xb(8'h7f, rx);
    xb(8'h00, rx);
    xb(8'h00, rx);
    u_mst.desel();
    `CHK(rx, 8'h7f ^ 8'h5a)
    // one fetch at the last address or dummy byte, then one per data byte
    `CHK(rd_cnt, r0 + 5)
  endtask : s_read

  // status write ignores its data's latch bit and clears the latch, protect pin refuses
  task automatic s_stat();
    stat_wr(8'h8e);
    `CHK(o_status, 8'hcc)
    i_wp_n = 1'b0;
    stat_wr(8'h00);
    `CHK(o_status, 8'hcc)
    i_wp_n = 1'b1;
    stat_wr(8'h00);
    `CHK(o_status, 8'h40)
  endtask : s_stat

  // unknown opcode and a cut-off opcode leave no trace
  task automatic s_junk();
    c0 = cmd_cnt;
    o0 = oe_cnt;
    u_mst.sel(1'b0);
    xb(8'h77, rx);
    xb(`SNF_OP_LATCH_SET, rx);
    xb(`SNF_OP_STATUS_READ, rx);
    xb(8'h00, rx);
    u_mst.desel();
    `CHK(cmd_cnt, c0)
    `CHK(oe_cnt, o0)
    u_mst.sel(1'b0);
    u_mst.shift(`SNF_OP_LATCH_SET, 7, rx);
    u_mst.desel();
    `CHK(cmd_cnt, c0)
    `CHK(o_status, 8'h40)
  endtask : s_junk

  // reset in mid-run drops latch and mode, next command works
  task automatic s_reset();
    cmd1(`SNF_OP_LATCH_SET, 1'b1);
    `CHK(o_status, 8'h42)
    i_rst = 1'b1;
    repeat (4) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_mclk);
    `CHK(o_status, 8'h40)
    `CHK(o_mode3, 1'b0)
    `CHK(so_oe_n, 1'b1)
    cmd1(`SNF_OP_LATCH_SET, 1'b0);
    `CHK(o_status, 8'h42)
    cmd1(`SNF_OP_LATCH_CLEAR, 1'b0);
    `CHK(o_status, 8'h40)
  endtask : s_reset

  // all nine opcodes recognised, modes alternating
  task automatic s_table();
    logic [7:0] ops [9];
    ops = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0b, 8'h02, 8'hb9, 8'h9f};
    for (int i = 0; i < 9; i++) begin
      c0 = cmd_cnt;
      cmd1(ops[i], i[0]);
      `CHK(cmd_cnt, c0 + 1)
      `CHK(o_opcode, ops[i])
    end
  endtask : s_table

  ////////////////////////////////////////////////////////////////////////////
  // verdict and main sequence
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  initial begin
    {error_cnt, num_checks, cmd_cnt, wr_cnt, oe_cnt, oe_bad, rd_cnt} = '0;
    cs_hist_q = 8'h00;
    i_rst     = 1'b1;
    i_wp_n    = 1'b1;
    repeat (4) @(negedge i_mclk);
    i_rst = 1'b0;
    // settle time before the first select
    repeat (8) @(negedge i_mclk);
    s_power();
    s_latch();
    s_write();
    s_read();
    s_stat();
    s_junk();
    s_reset();
    s_table();
    `CHK(oe_bad, 0)
    conclude();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge i_mclk);
    error_cnt++;
    conclude();
  end
endmodule : spi_nvram_command_frontend_test

`default_nettype wire
